/* File: logic/iprg_top.sv */
// Interrupt priority register for timer 2, compare 2 and capture 2
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
// Behaviour
// - Timer two priority is a read/write field in bits 14 to 12.
// - Compare two priority is a read/write field in bits 10 to 8.
// - Capture two priority is a read/write field in bits 6 to 4.
// - Field value is a binary level 1 to 7; zero disables source.
// - Bits 15, 11, 7 and 3 to 0 read zero, writes ignored.
module iprg_top
    import iprg_pkg::*;
(
    input  wire logic        pclk,                  // System clock
    input  wire logic        presetn,               // Async reset, low
    input  wire logic        psel,                  // APB select
    input  wire logic        penable,               // APB access phase
    input  wire logic        pwrite,                // APB write
    input  wire logic [11:0] paddr,                 // APB byte address
    input  wire logic [31:0] pwdata,                // APB write data
    output logic      [31:0] prdata,                // APB read data
    output logic             pready,                // APB ready
    output logic             pslverr,               // APB error
    output logic      [2:0]  timer_two_irq_level,   // Timer 2 level
    output logic      [2:0]  compare_two_irq_level, // Compare 2 level
    output logic      [2:0]  capture_two_irq_level, // Capture 2 level
    output logic      [2:0]  src_enable             // Per-source enables
);

    logic [15:0] prio_q, prio_d;
    logic [31:0] rdata_q, rdata_d;
    logic        ready_q, ready_d;
    logic        err_q, err_d;
    logic [2:0]  en_q, en_d;
    logic        setup;
    logic        access;
    logic        hit_prio, hit_stat;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode; no wait states, registered answer in the cycle after setup
    assign setup    = psel && !penable;
    // Access edge: the master samples pready high here and the transfer ends
    assign access   = psel && penable && ready_q;
    assign hit_prio = (paddr == IPRG_PRIO_OFFSET);
    assign hit_stat = (paddr == IPRG_STATUS_OFFSET);

    // Next register and answer values
    always_comb begin
        prio_d  = prio_q;
        rdata_d = 32'h0000_0000;
        ready_d = 1'b0;
        err_d   = 1'b0;
        if (setup) begin
            ready_d = 1'b1;
            if (hit_prio && !pwrite) begin
                rdata_d = {16'h0000, prio_q};
            end else if (hit_stat && !pwrite) begin
                rdata_d = {29'h0000_0000, en_q};
            end else if (!hit_prio) begin
                err_d = 1'b1; // Unmapped or write to read-only status
            end
        end
        // Write lands only on the edge where the master samples pready
        // high, so the register never moves before the transfer completes
        if (access && pwrite && hit_prio) begin
            // Unimplemented bits masked off so they stay zero
            prio_d = pwdata[15:0] & IPRG_IMPL_MASK;
        end
        // A zero level disables the source
        en_d[2] = prio_d[IPRG_TMR_LSB +: 3] != IPRG_LEVEL_OFF;
        en_d[1] = prio_d[IPRG_OC_LSB +: 3] != IPRG_LEVEL_OFF;
        en_d[0] = prio_d[IPRG_IC_LSB +: 3] != IPRG_LEVEL_OFF;
    end

    // State registers; write lands in the access cycle edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prio_q  <= IPRG_PRIO_RESET;
            rdata_q <= 32'h0000_0000;
            ready_q <= 1'b0;
            err_q   <= 1'b0;
            en_q    <= IPRG_ENABLE_RESET;
        end else begin
            prio_q  <= prio_d;
            rdata_q <= rdata_d;
            ready_q <= ready_d;
            err_q   <= err_d;
            en_q    <= en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops
    assign prdata                = rdata_q;
    assign pready                = ready_q;
    assign pslverr               = err_q;
    assign timer_two_irq_level   = prio_q[IPRG_TMR_LSB +: 3];
    assign compare_two_irq_level = prio_q[IPRG_OC_LSB +: 3];
    assign capture_two_irq_level = prio_q[IPRG_IC_LSB +: 3];
    assign src_enable            = en_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks; a write lands on the access edge, so levels, enables and
    // the register show its value from the next sampling edge on

    // Unimplemented bits never hold a one
    AST_UNIMPL_ZERO: assert property (
        @(posedge pclk) disable iff (!presetn)
        (prio_q & ~IPRG_IMPL_MASK) == 16'h0000
    ) else $error("unimplemented bit set");

    // Timer field takes bits 14 to 12 of the write data
    AST_TMR_WRITE: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && hit_prio |=>
            timer_two_irq_level == $past(pwdata[14:12])
    ) else $error("timer level not written");

    // Compare field takes bits 10 to 8 of the write data
    AST_OC_WRITE: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && hit_prio |=>
            compare_two_irq_level == $past(pwdata[10:8])
    ) else $error("compare level not written");

    // Capture field takes bits 6 to 4 of the write data
    AST_IC_WRITE: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && hit_prio |=>
            capture_two_irq_level == $past(pwdata[6:4])
    ) else $error("capture level not written");

    // A zero level turns the timer source off, any other level turns it on
    AST_DISABLE: assert property (
        @(posedge pclk) disable iff (!presetn)
        src_enable[2] == (timer_two_irq_level != IPRG_LEVEL_OFF)
    ) else $error("enable does not follow level");

    // Same for the compare source
    AST_OC_DISABLE: assert property (
        @(posedge pclk) disable iff (!presetn)
        src_enable[1] == (compare_two_irq_level != IPRG_LEVEL_OFF)
    ) else $error("compare enable does not follow level");

    // Same for the capture source
    AST_IC_DISABLE: assert property (
        @(posedge pclk) disable iff (!presetn)
        src_enable[0] == (capture_two_irq_level != IPRG_LEVEL_OFF)
    ) else $error("capture enable does not follow level");

    // A read answers in the access cycle with the register value
    AST_READBACK: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup && !pwrite && hit_prio |=>
            pready && prdata == {16'h0000, $past(prio_q)}
    ) else $error("readback wrong");

    // Unimplemented bits read as zero whatever was written to them
    AST_READ_UNIMPL: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup && !pwrite && hit_prio |=>
            (prdata[15:0] & ~IPRG_IMPL_MASK) == 16'h0000
    ) else $error("unimplemented bit read as one");

    // Writes to unimplemented bits are dropped
    AST_WRITE_MASK: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && pwrite && hit_prio |=>
            prio_q == ($past(pwdata[15:0]) & IPRG_IMPL_MASK)
    ) else $error("write not masked");

    // Nothing but a completed write to the register changes it
    AST_HOLD: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(access && pwrite && hit_prio) |=> $stable(prio_q)
    ) else $error("register changed without write");

    // Timer level holds between writes
    AST_TMR_HOLD: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(access && pwrite && hit_prio) |=> $stable(timer_two_irq_level)
    ) else $error("timer level changed without write");

    // Compare level holds between writes
    AST_OC_HOLD: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(access && pwrite && hit_prio) |=> $stable(compare_two_irq_level)
    ) else $error("compare level changed without write");

    // Capture level holds between writes
    AST_IC_HOLD: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(access && pwrite && hit_prio) |=> $stable(capture_two_irq_level)
    ) else $error("capture level changed without write");

    // Reset puts every field at level 4
    AST_RESET_VAL: assert property (
        @(posedge pclk)
        !presetn |=> prio_q == IPRG_PRIO_RESET || !presetn
    ) else $error("reset value wrong");

    // Levels seen at the first edge after reset is released
    AST_RESET_RELEASE: assert property (
        @(posedge pclk)
        $rose(presetn) |-> timer_two_irq_level == IPRG_LEVEL_RESET &&
            compare_two_irq_level == IPRG_LEVEL_RESET &&
            capture_two_irq_level == IPRG_LEVEL_RESET
    ) else $error("level after reset wrong");

    // All sources are enabled at the first edge after reset
    AST_ENABLE_RESET: assert property (
        @(posedge pclk)
        $rose(presetn) |-> src_enable == IPRG_ENABLE_RESET
    ) else $error("enable after reset wrong");

    // The status word reports which sources are enabled
    AST_STATUS_READ: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup && !pwrite && hit_stat |=>
            prdata == {29'h0000_0000, $past(src_enable)}
    ) else $error("status read wrong");

endmodule // iprg_top

/* File: shared/iprg_pkg.sv */
// Constants for the interrupt priority register block
package iprg_pkg;
    localparam logic [11:0] IPRG_PRIO_OFFSET   = 12'h000;
    localparam logic [11:0] IPRG_STATUS_OFFSET = 12'h004;
    localparam int          IPRG_TMR_LSB       = 12;
    localparam int          IPRG_OC_LSB        = 8;
    localparam int          IPRG_IC_LSB        = 4;
    localparam logic [2:0]  IPRG_LEVEL_RESET   = 3'h4;
    localparam logic [2:0]  IPRG_LEVEL_OFF     = 3'h0;
    localparam logic [2:0]  IPRG_ENABLE_RESET  = 3'h7;
    localparam logic [15:0] IPRG_PRIO_RESET    = 16'h4440;
    localparam logic [15:0] IPRG_IMPL_MASK     = 16'h7770;
endpackage

/* File: verification/iprg_top_bench.sv */
// Self-checking bench for the interrupt priority register
`timescale 1ns/10ps
module iprg_top_bench;
import iprg_pkg::*;
logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, prdata, rd;
logic        pready, pslverr, err;
logic [2:0]  tl, cl, kl, en;
int          num_errors = 0, checks = 0, cyc = 0;
// Clock and hang guard
always #50 pclk = ~pclk;
always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
        num_errors++;
        stop_test();
    end
end
iprg_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_two_irq_level(tl), .compare_two_irq_level(cl),
    .capture_two_irq_level(kl), .src_enable(en));
////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
        num_errors++;
        $display("unexpected at %0t: %h expected %h", $time, s, e);
    end
endtask
// Hold the request until pready is sampled high, then release
task automatic apb(input logic w, input logic [11:0] a,
                   input logic [31:0] d);
    @(posedge pclk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
endtask
task automatic t_reset();
    apb(0, IPRG_PRIO_OFFSET, 0); chk(rd, 32'h4440);
    chk({tl, cl, kl, en}, 12'h927);
    $display("reset values done");
endtask
// Unimplemented bits stay zero even when written high
task automatic t_fields();
    apb(1, IPRG_PRIO_OFFSET, 32'hffffffff);
    @(negedge pclk);
    chk({tl, cl, kl, en}, 12'hfff);
    apb(0, IPRG_PRIO_OFFSET, 0);
    chk(rd, 32'h7770);
    apb(1, IPRG_PRIO_OFFSET, 32'h5320);
    @(negedge pclk);
    chk({tl, cl}, 6'h2b);
    chk(kl, 3'h2);
    apb(1, IPRG_PRIO_OFFSET, 32'h1000);
    @(negedge pclk);
    chk(en, 3'h4);
    apb(0, IPRG_STATUS_OFFSET, 0);
    chk(rd, 32'h4);
    $display("field tests done");
endtask
// Refused accesses must leave the register alone
task automatic t_err();
    apb(0, 12'h008, 0); chk(err, 1'b1);
    apb(1, IPRG_STATUS_OFFSET, 32'h7); chk(err, 1'b1);
    apb(0, IPRG_PRIO_OFFSET, 0);
    chk(rd, 32'h1000);
    $display("error tests done");
endtask
// Reset in mid-run brings every field back to level 4
task automatic t_rerun();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
endtask
task automatic stop_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_reset();
    t_fields();
    t_err();
    t_rerun();
    stop_test();
end
endmodule // iprg_top_bench
